// [ddrmi_pkg.sv]
/*
  Constants, field layouts, command codes and carrier types for the
  memory-side command, mode and burst logic.
  Assumes one 125 MHz clock and commands sampled on its rising edge.
*/
package ddrmi_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 13;
   localparam int COL_W      = 10;
   localparam int DATA_W     = 8;
   localparam int MEM_ROW_W  = 2;
   localparam int MEM_COL_W  = 5;
   localparam int MEM_IDX_W  = 2 + MEM_ROW_W + MEM_COL_W;
   localparam int FIFO_DEPTH = 32;

   // ----------------------------------------------------------------
   // Mode register fields
   // ----------------------------------------------------------------
   localparam int MR_BL_LSB      = 0;
   localparam int MR_BT_BIT      = 3;
   localparam int MR_CL_LSB      = 4;
   localparam int MR_OP_LSB      = 7;
   localparam int MR_DLL_RST_BIT = 8;
   localparam int AP_BIT         = 10;
   localparam int EMR_DLL_BIT    = 0;

   localparam logic [ADDR_W-1:0] MR_RESET  = 13'h0000;
   localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0001;

   localparam logic [2:0] BL_2  = 3'h1;
   localparam logic [2:0] BL_4  = 3'h2;
   localparam logic [2:0] BL_8  = 3'h3;
   localparam logic [2:0] CL_2  = 3'h2;
   localparam logic [2:0] CL_25 = 3'h6;
   localparam logic [2:0] CL_3  = 3'h3;

   // Latency minus one, in clocks
   localparam logic [1:0] LAT_M1_2 = 2'h1;
   localparam logic [1:0] LAT_M1_3 = 2'h2;

   localparam logic [5:0] OP_NORMAL    = 6'h00;
   localparam logic [5:0] OP_DLL_RESET = 6'h02;

   localparam logic [1:0] SEL_MR  = 2'h0;
   localparam logic [1:0] SEL_EMR = 2'h1;

   // ----------------------------------------------------------------
   // Command codes {ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_MRS   = 3'h0;
   localparam logic [2:0] CMD_REF   = 3'h1;
   localparam logic [2:0] CMD_PRE   = 3'h2;
   localparam logic [2:0] CMD_ACT   = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ  = 3'h5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } ddrmi_cmd_s;

   typedef struct packed {
      logic [1:0]        bank;
      logic [ADDR_W-1:0] addr;
   } ddrmi_addr_s;

   typedef enum logic [2:0] {
      INIT_PRE1    = 3'h0,
      INIT_EMR     = 3'h1,
      INIT_MR_RST  = 3'h2,
      INIT_PRE2    = 3'h3,
      INIT_REF1    = 3'h4,
      INIT_REF2    = 3'h5,
      INIT_MR_NORM = 3'h6,
      INIT_DONE    = 3'h7
   } ddrmi_init_e;

endpackage

// [ddrmi_fifo.sv]
/*
  Write-data FIFO with valid and ready on both sides.
  Assumes a power-of-two depth and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module ddrmi_fifo
#(
   parameter int W = 8,
   parameter int D = 32
)
(
   input  wire logic         core_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL = CW'(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          in_ready_reg;
   wire           push = in_valid_i & in_ready_reg;
   wire           pop  = out_ready_i & (count_reg != '0);

   assign count_next  = count_reg + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
   assign in_ready_o  = in_ready_reg;
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem[rptr_reg];

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (push)
      begin
         mem[wptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         wptr_reg     <= '0;
         rptr_reg     <= '0;
         count_reg    <= '0;
         in_ready_reg <= 1'b0;
      end
      else
      begin
         wptr_reg     <= wptr_reg + AW'(push);
         rptr_reg     <= rptr_reg + AW'(pop);
         count_reg    <= count_next;
         in_ready_reg <= (count_next != FULL);
      end
   end
endmodule // ddrmi_fifo

// [ddrmi_core.sv]
/*
  Memory-side command decoding, power-up sequence tracking, mode and
  extended mode registers, bank row tracking, wrapped burst addressing
  and read latency for a small four-bank array.
  Assumes commands, address and write-data stream are synchronous to
  core_clk_i; the pad layer resolves the data and strobe wires.
*/
`timescale 1ns/100ps
module ddrmi_core
(
   input  wire logic                            core_clk_i,
   input  wire logic                            reset_i,
   input  wire logic                            cke_i,
   input  wire ddrmi_pkg::ddrmi_cmd_s           cmd_i,
   input  wire ddrmi_pkg::ddrmi_addr_s          cmd_addr_i,
   input  wire logic [ddrmi_pkg::DATA_W-1:0]    wr_data_i,
   input  wire logic                            wr_valid_i,
   output logic                                 wr_ready_o,
   output logic [ddrmi_pkg::DATA_W-1:0]         dq_o,
   output logic                                 dq_oe_n_o,
   output logic                                 dqs_o,
   output logic                                 dqs_oe_n_o,
   output logic                                 init_done_o,
   output logic                                 dll_enabled_o,
   output logic [ddrmi_pkg::ADDR_W-1:0]         refresh_row_o
);
   import ddrmi_pkg::*;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0]    mode_reg;
   logic [ADDR_W-1:0]    emr_reg;
   logic [ADDR_W-1:0]    refresh_row_reg;
   logic                 init_done_reg;
   logic                 dll_en_reg;
   ddrmi_init_e          init_reg;
   ddrmi_init_e          init_next;
   logic [3:0]           row_open_reg;
   logic [ADDR_W-1:0]    open_row_reg [4];

   wire [2:0]            code    = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
   wire                  sel     = cke_i & ~cmd_i.cs_n;
   wire [1:0]            bank    = cmd_addr_i.bank;
   wire [ADDR_W-1:0]     addr    = cmd_addr_i.addr;
   wire [5:0]            op      = addr[ADDR_W-1:MR_OP_LSB];
   wire                  is_act  = sel & (code == CMD_ACT);
   wire                  is_read = sel & (code == CMD_READ);
   wire                  is_wr   = sel & (code == CMD_WRITE);
   wire                  is_pre  = sel & (code == CMD_PRE);
   wire                  is_ref  = sel & (code == CMD_REF);
   wire                  is_mrs  = sel & (code == CMD_MRS);
   wire                  op_norm = (op == OP_NORMAL);
   wire                  op_dllr = (op == OP_DLL_RESET);

   // Sequence commands pass before ready, all others wait for it
   wire act_take   = is_act & init_done_reg;
   wire read_take  = is_read & init_done_reg & row_open_reg[bank];
   wire write_take = is_wr & init_done_reg & row_open_reg[bank];
   wire pre_take   = is_pre & (init_done_reg | addr[AP_BIT]);
   wire ref_take   = is_ref & (init_done_reg | (init_reg == INIT_REF1) | (init_reg == INIT_REF2));
   wire mrs_mr_take  = is_mrs & (bank == SEL_MR) & (init_done_reg
                       | ((init_reg == INIT_MR_RST) & op_dllr)
                       | ((init_reg == INIT_MR_NORM) & op_norm));
   wire mrs_emr_take = is_mrs & (bank == SEL_EMR) & (init_done_reg
                       | ((init_reg == INIT_EMR) & ~addr[EMR_DLL_BIT]));

   // ----------------------------------------------------------------
   // Power-up sequence
   // ----------------------------------------------------------------
   always_comb
   begin
      init_next = init_reg;
      case (init_reg)
         INIT_PRE1:    if (pre_take) init_next = INIT_EMR;
         INIT_EMR:     if (mrs_emr_take) init_next = INIT_MR_RST;
         INIT_MR_RST:  if (mrs_mr_take) init_next = INIT_PRE2;
         INIT_PRE2:    if (pre_take) init_next = INIT_REF1;
         INIT_REF1:    if (ref_take) init_next = INIT_REF2;
         INIT_REF2:    if (ref_take) init_next = INIT_MR_NORM;
         INIT_MR_NORM: if (mrs_mr_take) init_next = INIT_DONE;
         INIT_DONE:    init_next = INIT_DONE;
         default:      init_next = INIT_PRE1;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         init_reg      <= INIT_PRE1;
         init_done_reg <= 1'b0;
      end
      else
      begin
         init_reg      <= init_next;
         init_done_reg <= (init_next == INIT_DONE);
      end
   end

   // ----------------------------------------------------------------
   // Mode registers and refresh counter
   // ----------------------------------------------------------------
   wire [ADDR_W-1:0] dll_rst_mask = ADDR_W'(1) << MR_DLL_RST_BIT;
   wire [ADDR_W-1:0] mode_next    = mrs_mr_take ? addr : (mode_reg & ~dll_rst_mask);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         mode_reg        <= MR_RESET;
         emr_reg         <= EMR_RESET;
         dll_en_reg      <= ~EMR_RESET[EMR_DLL_BIT];
         refresh_row_reg <= '0;
      end
      else
      begin
         mode_reg <= mode_next;
         if (mrs_emr_take)
         begin
            emr_reg <= addr;
            dll_en_reg <= ~addr[EMR_DLL_BIT];
         end
         if (ref_take)
         begin
            refresh_row_reg <= refresh_row_reg + ADDR_W'(1);
         end
      end
   end

   assign init_done_o   = init_done_reg;
   assign refresh_row_o = refresh_row_reg;
   assign dll_enabled_o = dll_en_reg;

   // Field decode shared by reads and writes; the latency decode serves reads only
   wire [2:0] bl_code = mode_reg[MR_BL_LSB +: 3];
   wire [2:0] cl_code = mode_reg[MR_CL_LSB +: 3];
   wire       bt_il   = mode_reg[MR_BT_BIT];
   wire [2:0] bl_mask = (bl_code == BL_8) ? 3'h7 :
                        (bl_code == BL_4) ? 3'h3 : 3'h1;
   wire [1:0] lat_m1  = (cl_code == CL_2) ? LAT_M1_2 : LAT_M1_3;

   // ----------------------------------------------------------------
   // Bank row tracking
   // ----------------------------------------------------------------
   generate
      for (genvar b = 0; b < 4; b++)
      begin : g_bank
         always_ff @(posedge core_clk_i)
         begin
            if (reset_i)
            begin
               row_open_reg[b] <= 1'b0;
               open_row_reg[b] <= '0;
            end
            else if (act_take & (bank == 2'(b)))
            begin
               row_open_reg[b] <= 1'b1;
               open_row_reg[b] <= addr;
            end
            else if (pre_take & (addr[AP_BIT] | (bank == 2'(b))))
            begin
               row_open_reg[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Burst address generation
   // ----------------------------------------------------------------
   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
                                                  input logic [2:0] idx,
                                                  input logic [2:0] mask,
                                                  input logic inter);
      logic [2:0] off;
      off = inter ? (base[2:0] ^ idx) : (base[2:0] + idx);
      burst_col = (base & ~{7'h00, mask}) | {7'h00, off & mask};
   endfunction

   logic [DATA_W-1:0]    mem [2**MEM_IDX_W];
   logic                 rd_pend_reg;
   logic                 rd_busy_reg;
   logic [1:0]           rd_wait_reg;
   logic [2:0]           rd_i_reg;
   logic [2:0]           rd_mask_reg;
   logic                 rd_il_reg;
   logic [COL_W-1:0]     rd_base_reg;
   logic [1:0]           rd_bank_reg;
   logic [MEM_ROW_W-1:0] rd_row_reg;
   logic                 wr_busy_reg;
   logic [2:0]           wr_i_reg;
   logic [2:0]           wr_mask_reg;
   logic                 wr_il_reg;
   logic [COL_W-1:0]     wr_base_reg;
   logic [1:0]           wr_bank_reg;
   logic [MEM_ROW_W-1:0] wr_row_reg;
   logic [DATA_W-1:0]    dq_reg;
   logic                 dq_oe_n_reg;
   logic                 dqs_reg;
   logic [DATA_W-1:0]    fifo_data;
   logic                 fifo_valid;

   wire [COL_W-1:0] rd_col  = burst_col(rd_base_reg, rd_i_reg, rd_mask_reg, rd_il_reg);
   wire [COL_W-1:0] wr_col  = burst_col(wr_base_reg, wr_i_reg, wr_mask_reg, wr_il_reg);
   wire [MEM_IDX_W-1:0] rd_idx = {rd_bank_reg, rd_row_reg, rd_col[MEM_COL_W-1:0]};
   wire [MEM_IDX_W-1:0] wr_idx = {wr_bank_reg, wr_row_reg, wr_col[MEM_COL_W-1:0]};
   wire rd_emit  = (rd_pend_reg & (rd_wait_reg == 2'h0)) | rd_busy_reg;
   wire wr_beat  = wr_busy_reg & fifo_valid;
   wire [ADDR_W-1:0] sel_row = open_row_reg[bank];

   // ----------------------------------------------------------------
   // Write data FIFO and write bursts
   // ----------------------------------------------------------------
   ddrmi_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_wr_fifo
   (
      .core_clk_i  (core_clk_i),
      .reset_i     (reset_i),
      .in_data_i   (wr_data_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (wr_busy_reg)
   );

   always_ff @(posedge core_clk_i)
   begin
      if (wr_beat)
      begin
         mem[wr_idx] <= fifo_data;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         wr_busy_reg <= 1'b0;
         wr_i_reg    <= '0;
         wr_mask_reg <= '0;
         wr_il_reg   <= 1'b0;
         wr_base_reg <= '0;
         wr_bank_reg <= '0;
         wr_row_reg  <= '0;
      end
      else if (write_take)
      begin
         wr_busy_reg <= 1'b1;
         wr_i_reg    <= '0;
         wr_mask_reg <= bl_mask;
         wr_il_reg   <= bt_il;
         wr_base_reg <= addr[COL_W-1:0];
         wr_bank_reg <= bank;
         wr_row_reg  <= sel_row[MEM_ROW_W-1:0];
      end
      else if (wr_beat)
      begin
         wr_i_reg    <= wr_i_reg + 3'h1;
         wr_busy_reg <= (wr_i_reg != wr_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // Read bursts with programmed latency
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         rd_pend_reg <= 1'b0;
         rd_busy_reg <= 1'b0;
         rd_wait_reg <= '0;
         rd_i_reg    <= '0;
         rd_mask_reg <= '0;
         rd_il_reg   <= 1'b0;
         rd_base_reg <= '0;
         rd_bank_reg <= '0;
         rd_row_reg  <= '0;
         dq_reg      <= '0;
         dq_oe_n_reg <= 1'b1;
         dqs_reg     <= 1'b0;
      end
      else
      begin
         if (read_take)
         begin
            rd_pend_reg <= 1'b1;
            rd_busy_reg <= 1'b0;
            rd_wait_reg <= lat_m1;
            rd_i_reg    <= '0;
            rd_mask_reg <= bl_mask;
            rd_il_reg   <= bt_il;
            rd_base_reg <= addr[COL_W-1:0];
            rd_bank_reg <= bank;
            rd_row_reg  <= sel_row[MEM_ROW_W-1:0];
         end
         else if (rd_emit)
         begin
            rd_pend_reg <= 1'b0;
            rd_i_reg    <= rd_i_reg + 3'h1;
            rd_busy_reg <= (rd_i_reg != rd_mask_reg);
         end
         else if (rd_pend_reg)
         begin
            rd_wait_reg <= rd_wait_reg - 2'h1;
         end
         dq_oe_n_reg <= ~(rd_emit & ~read_take);
         if (rd_emit & ~read_take)
         begin
            dq_reg  <= mem[rd_idx];
            dqs_reg <= ~rd_i_reg[0];
         end
         else
         begin
            dqs_reg <= 1'b0;
         end
      end
   end

   assign dq_o       = dq_reg;
   assign dq_oe_n_o  = dq_oe_n_reg;
   assign dqs_o      = dqs_reg;
   assign dqs_oe_n_o = dq_oe_n_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_float_before_ready;
      @(posedge core_clk_i) disable iff (reset_i)
      !init_done_o |-> dq_oe_n_o && dqs_oe_n_o;
   endproperty
   a_float_before_ready: assert property (p_float_before_ready) else $error("data driven before ready");

   property p_dll_self_clear;
      @(posedge core_clk_i) disable iff (reset_i)
      mode_reg[MR_DLL_RST_BIT] && !mrs_mr_take |=> !mode_reg[MR_DLL_RST_BIT];
   endproperty
   a_dll_self_clear: assert property (p_dll_self_clear) else $error("loop reset bit stuck");

   property p_mode_hold;
      @(posedge core_clk_i) disable iff (reset_i)
      !mrs_mr_take |=> $stable({mode_reg[12:9], mode_reg[7:0]});
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without load");

   property p_refresh_kept;
      @(posedge core_clk_i) disable iff (reset_i)
      (mrs_mr_take || mrs_emr_take) |=> $stable(refresh_row_reg);
   endproperty
   a_refresh_kept: assert property (p_refresh_kept) else $error("mode load moved refresh counter");

   property p_act_opens;
      @(posedge core_clk_i) disable iff (reset_i)
      act_take |=> row_open_reg[$past(bank)] && open_row_reg[$past(bank)] == $past(addr);
   endproperty
   a_act_opens: assert property (p_act_opens) else $error("activate did not open row");

   property p_lat_two;
      @(posedge core_clk_i) disable iff (reset_i)
      read_take && lat_m1 == LAT_M1_2 ##1 !read_take ##1 !read_take |-> ##1 !dq_oe_n_o;
   endproperty
   a_lat_two: assert property (p_lat_two) else $error("latency two data late");

   property p_lat_three;
      @(posedge core_clk_i) disable iff (reset_i)
      read_take && lat_m1 == LAT_M1_3 ##1 !read_take [*3] |-> $past(dq_oe_n_o) && dq_oe_n_o ##1 !dq_oe_n_o;
   endproperty
   a_lat_three: assert property (p_lat_three) else $error("latency three data misplaced");

   property p_wrap_block;
      @(posedge core_clk_i) disable iff (reset_i)
      rd_emit |-> (rd_col & ~{7'h00, rd_mask_reg}) == (rd_base_reg & ~{7'h00, rd_mask_reg});
   endproperty
   a_wrap_block: assert property (p_wrap_block) else $error("burst left its block");

   property p_seq_step;
      @(posedge core_clk_i) disable iff (reset_i)
      rd_busy_reg && !rd_il_reg && !$past(read_take) |->
         (rd_col[2:0] & rd_mask_reg) == (($past(rd_col[2:0]) + 3'h1) & rd_mask_reg);
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequential order broken");

   property p_emr_target;
      @(posedge core_clk_i) disable iff (reset_i)
      mrs_emr_take |=> emr_reg == $past(addr) && $stable(mode_reg[7:0]);
   endproperty
   a_emr_target: assert property (p_emr_target) else $error("extended load misrouted");

   property p_ignore_early;
      @(posedge core_clk_i) disable iff (reset_i)
      !init_done_reg && (is_read || is_act) |=> !rd_pend_reg && $stable(row_open_reg);
   endproperty
   a_ignore_early: assert property (p_ignore_early) else $error("command taken before ready");

   property p_dll_reset_load;
      @(posedge core_clk_i) disable iff (reset_i)
      mrs_mr_take && op_dllr |=> mode_reg[MR_DLL_RST_BIT] ##1 !mode_reg[MR_DLL_RST_BIT] || $past(mrs_mr_take);
   endproperty
   a_dll_reset_load: assert property (p_dll_reset_load) else $error("loop reset load lost");
endmodule // ddrmi_core

// [ddrmi_ctrl_model.sv]
/* Controller model: power-up sequence, commands, write data.
   Assumes the core samples everything on the rising clock edge. */
`timescale 1ns/100ps
module ddrmi_ctrl_model
(
   input  wire logic                    core_clk_i,
   input  wire logic                    wr_ready_i,
   output ddrmi_pkg::ddrmi_cmd_s        cmd_o,
   output ddrmi_pkg::ddrmi_addr_s       addr_o,
   output logic                         cke_o,
   output logic [ddrmi_pkg::DATA_W-1:0] wr_data_o,
   output logic                         wr_valid_o
);
   import ddrmi_pkg::*;
   initial
   begin
      cmd_o = 4'hF;
      addr_o = '0;
      cke_o = 1'b0;
      wr_data_o = '0;
      wr_valid_o = 1'b0;
   end
   task automatic gate_on();
      cke_o <= 1'b1;
   endtask
   // Idle address shows the inverse of the last one
   task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
      @(posedge core_clk_i);
      cmd_o <= {1'b0, c};
      addr_o <= {b, a};
      @(posedge core_clk_i);
      cmd_o <= 4'hF;
      addr_o <= ~{b, a};
   endtask
   task automatic push4(input logic [7:0] d);
      for (int i = 0; i < 4; i++)
      begin
         wr_data_o <= d + 8'(i);
         wr_valid_o <= 1'b1;
         @(negedge core_clk_i);
         while (wr_ready_i !== 1'b1) @(negedge core_clk_i);
         @(posedge core_clk_i);
      end
      wr_valid_o <= 1'b0;
   endtask
   task automatic init_seq();
      issue(CMD_PRE, 2'h0, 13'h0400);
      issue(CMD_MRS, SEL_EMR, 13'h0000);
      issue(CMD_MRS, SEL_MR, 13'h0122);
      repeat (200) @(posedge core_clk_i);
      issue(CMD_PRE, 2'h0, 13'h0400);
      issue(CMD_REF, 2'h0, 13'h0000);
      issue(CMD_REF, 2'h0, 13'h0000);
      issue(CMD_MRS, SEL_MR, 13'h0022);
   endtask
endmodule // ddrmi_ctrl_model

// [tb_ddr_mode_init_burst_logic.sv]
/* Testbench: start-up, mode loads, wrapped bursts, read latency.
   Assumes ddrmi_core and the controller model. */
`timescale 1ns/100ps
module tb_ddr_mode_init_burst_logic;
   import ddrmi_pkg::*;
   logic core_clk_i, reset_i, cke_i, wr_valid_i, wr_ready_o, dq_oe_n_o, dqs_o, dqs_oe_n_o;
   logic init_done_o, dll_enabled_o;
   logic [7:0] wr_data_i, dq_o;
   logic [12:0] refresh_row_o;
   ddrmi_cmd_s cmd_i;
   ddrmi_addr_s cmd_addr_i;
   int fail_count = 0;
   int num_checks = 0;
   ddrmi_core dut_u (.core_clk_i, .reset_i, .cke_i, .cmd_i, .cmd_addr_i, .wr_data_i, .wr_valid_i,
      .wr_ready_o, .dq_o, .dq_oe_n_o, .dqs_o, .dqs_oe_n_o, .init_done_o, .dll_enabled_o, .refresh_row_o);
   ddrmi_ctrl_model ctrl_u (.core_clk_i, .wr_ready_i(wr_ready_o), .cmd_o(cmd_i), .addr_o(cmd_addr_i),
      .cke_o(cke_i), .wr_data_o(wr_data_i), .wr_valid_o(wr_valid_i));
   initial
   begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Read bank 1 at col after lat clocks, expect words w[7:0] first
   task automatic read_burst(input logic [12:0] col, input int lat, input logic [31:0] w);
      ctrl_u.issue(CMD_READ, 2'h1, col);
      repeat (lat) @(posedge core_clk_i);
      #1;
      for (int i = 0; i < 4; i++)
      begin
         check("dq_oe_n", 16'(dq_oe_n_o), 16'h0);
         check("dqs_oe_n", 16'(dqs_oe_n_o), 16'h0);
         check("dq", 16'(dq_o), 16'(w[8*i +: 8]));
         check("dqs", 16'(dqs_o), 16'(!i[0]));
         @(posedge core_clk_i);
         #1;
      end
      check("dq_oe_n end", 16'(dq_oe_n_o), 16'h1);
      check("dqs_oe_n end", 16'(dqs_oe_n_o), 16'h1);
   endtask
   // Precharge, load mode, reopen bank 1, read from column 1
   task automatic mode_read(input logic [12:0] mode, input int lat, input logic [31:0] w);
      ctrl_u.issue(CMD_PRE, 2'h0, 13'h0400);
      ctrl_u.issue(CMD_MRS, SEL_MR, mode);
      ctrl_u.issue(CMD_ACT, 2'h1, 13'h0000);
      #1;
      check("refresh kept", 16'(refresh_row_o), 16'h2);
      read_burst(13'h0001, lat, w);
   endtask
   initial
   begin
      reset_i = 1'b1;
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      check("oe reset", 16'(dq_oe_n_o), 16'h1);
      check("row reset", 16'(refresh_row_o), 16'h0);
      repeat (25000) @(posedge core_clk_i);
      ctrl_u.gate_on();
      ctrl_u.issue(CMD_ACT, 2'h1, 13'h0000);
      ctrl_u.issue(CMD_READ, 2'h1, 13'h0000);
      repeat (6) @(posedge core_clk_i);
      #1;
      check("early read", 16'(dq_oe_n_o), 16'h1);
      check("early done", 16'(init_done_o), 16'h0);
      ctrl_u.init_seq();
      @(posedge core_clk_i);
      #1;
      check("done", 16'(init_done_o), 16'h1);
      check("dll", 16'(dll_enabled_o), 16'h1);
      check("refresh", 16'(refresh_row_o), 16'h2);
      ctrl_u.issue(CMD_ACT, 2'h1, 13'h0000);
      ctrl_u.push4(8'hA0);
      ctrl_u.issue(CMD_WRITE, 2'h1, 13'h0000);
      repeat (6) @(posedge core_clk_i);
      #1;
      check("ready", 16'(wr_ready_o), 16'h1);
      read_burst(13'h0001, 2, 32'hA0A3A2A1);
      mode_read(13'h002A, 2, 32'hA2A3A0A1);
      mode_read(13'h0062, 3, 32'hA0A3A2A1);
      mode_read(13'h0032, 3, 32'hA0A3A2A1);
      complete_run();
   end
   initial
   begin
      #400000;
      fail_count++;
      complete_run();
   end
endmodule // tb_ddr_mode_init_burst_logic
